/* File: shared/pcwdt_pkg.sv */
package pcwdt_pkg;
   // register byte offsets
   localparam logic [7:0] PendOffset = 8'h04;
   localparam logic [7:0] MaskStateOffset = 8'h08;
   localparam logic [7:0] MaskClearOffset = 8'h0c;
   localparam logic [7:0] MaskSetOffset = 8'h10;
   localparam logic [7:0] RouteMapOffset = 8'h40;
   localparam logic [7:0] ConfigOffset = 8'h90;
   localparam logic [7:0] CountOffset = 8'h94;
   localparam logic [7:0] InitialOffset = 8'h98;
   // configuration field positions
   localparam int CfgEnableBit = 0;
   localparam int CfgTypeLo = 1;
   localparam int CfgTypeHi = 3;
   localparam int CfgDebugContBit = 4;
   localparam int CfgWaitContBit = 5;
   localparam int CfgResetSeenBit = 6;
   // route map and pending field positions
   localparam int MapLineBit = 31;
   localparam int MapNmiBit = 30;
   localparam int MapYieldBit = 29;
   localparam int MapFieldHi = 5;
   localparam int WdPendBit = 0;
   // expiry types
   localparam logic [2:0] TypeSecond = 3'h1;
   localparam logic [2:0] TypeOneShot = 3'h2;
   localparam logic [2:0] TypeInterval = 3'h3;
   // reset values
   localparam logic [31:0] MapReset = 32'h80000000;
   localparam logic [31:0] CountReset = 32'h00000000;
   localparam logic [31:0] InitialReset = 32'h00000000;
   // cluster reset pulse length in cycles
   localparam int ClusterResetCycles = 4;
   localparam logic [2:0] ClusterResetLen = 3'(ClusterResetCycles);
endpackage

/* File: logic/pcwdt_top.sv */
// How it works
// RQ1 - wait-continue clear: count pauses in wait or low-power states
// RQ2 - debug-continue clear: count pauses while processor in debug mode
// RQ3 - config bits 3:1 pick the expiry action
// RQ4 - type 2: expiry raises interrupt and stops counting
// RQ5 - type 1: first expiry interrupts and reloads, second resets cluster
// RQ6 - type 3: every expiry interrupts, reloads and keeps counting
// RQ7 - counts only while enable bit is one
// RQ8 - each write of one to enable copies initial into current count
// RQ9 - software clears enable, writes initial, then sets enable
// RQ10 - current count at 0x94 is read-only live value
// RQ11 - initial count at 0x98 writable, used for every reload
// RQ12 - interrupt sets pending bit 0 at 0x04
// RQ13 - mask bit 0 at 0x08 gates pending interrupt forwarding
// RQ14 - set-mask 0x10 enables, clear-mask 0x0c disables
// RQ15 - cluster reset ignores the mask bit
// RQ16 - map at 0x40 routes to line, nmi or yield qualifier
// RQ17 - normal mode: map value n drives line n, only 0..5
// RQ18 - external-controller mode: map value driven encoded on six lines
// RQ19 - continue bits live in config register 0x90
// RQ20 - current count is a 32-bit down-counter
// RQ21 - software sets at most one destination-type bit
// RQ22 - one decrement per clock, expiry on transition to zero
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ns
module pcwdt_top
   import pcwdt_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // processor state pins
   input wire logic waitState,
   input wire logic debugModeFlag,
   input wire logic externalControllerMode,
   // processor interrupt and cluster reset outputs
   output logic [5:0] interruptLines,
   output logic nmiLine,
   output logic [15:0] yieldQualifierLines,
   output logic clusterReset
);
   import pcwdt_pkg::*;

   logic [31:0] countR;
   logic [31:0] initialR;
   logic [31:0] mapR;
   logic enableR;
   logic [2:0] typeR;
   logic debugContR;
   logic waitContR;
   logic armedR;
   logic pendR;
   logic maskR;
   logic [2:0] rstCntR;
   logic ackR;
   logic [31:0] datR;
   logic [1:0] waitSyncR;
   logic [1:0] dbgSyncR;
   logic [1:0] eicSyncR;
   logic wrStb;
   logic wrEnable;
   logic paused;
   logic expire;
   logic fire;
   logic [31:0] wrData;
   logic [31:0] laneMask;
   logic [5:0] mapField;

   // pin inputs through two flops
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         waitSyncR <= 2'h0;
         dbgSyncR <= 2'h0;
         eicSyncR <= 2'h0;
      end
      else
      begin
         waitSyncR <= {waitSyncR[0], waitState};
         dbgSyncR <= {dbgSyncR[0], debugModeFlag};
         eicSyncR <= {eicSyncR[0], externalControllerMode};
      end
   end

   // bus write strobe, taken once per request
   assign wrStb = wb_cyc_i && wb_stb_i && wb_we_i && !ackR;
   // byte lanes picked by sel; unselected lanes keep their old bits
   assign laneMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign wrData = laneMask & wb_dat_i;
   // destination field of the route map
   assign mapField = mapR[MapFieldHi:0];
   // RQ8 enable write reload
   assign wrEnable = wrStb && wb_adr_i == ConfigOffset && wb_sel_i[0]
                     && wb_dat_i[CfgEnableBit];
   // RQ1 RQ2 pause conditions
   assign paused = (!waitContR && waitSyncR[1]) || (!debugContR && dbgSyncR[1]);
   // RQ22 transition to zero
   assign expire = enableR && !paused && countR == 32'h00000001;
   assign fire = expire && typeR inside {TypeSecond, TypeOneShot, TypeInterval};

   // configuration register fields
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         enableR <= 1'b0;
         typeR <= 3'h0;
         debugContR <= 1'b0;
         waitContR <= 1'b0;
      end
      else if (wrStb && wb_adr_i == ConfigOffset && wb_sel_i[0])
      begin
         // RQ7 RQ3 RQ19 config fields
         enableR <= wb_dat_i[CfgEnableBit];
         typeR <= wb_dat_i[CfgTypeHi:CfgTypeLo];
         debugContR <= wb_dat_i[CfgDebugContBit];
         waitContR <= wb_dat_i[CfgWaitContBit];
      end
      else if (fire && typeR == TypeOneShot)
      begin
         // RQ4 one-shot halts
         enableR <= 1'b0;
      end
   end

   // RQ11 initial count and route map
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         initialR <= InitialReset;
         mapR <= MapReset;
      end
      else if (wrStb)
      begin
         if (wb_adr_i == InitialOffset)
            initialR <= (initialR & ~laneMask) | wrData;
         // RQ16 map register write
         if (wb_adr_i == RouteMapOffset)
            mapR <= ((mapR & ~laneMask) | wrData) & 32'he000003f;
      end
   end

   // RQ20 32-bit down counter
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         countR <= CountReset;
      // RQ8 reload on enable
      else if (wrEnable)
         countR <= initialR;
      // RQ5 RQ6 reload on expiry
      else if (expire && (typeR == TypeSecond || typeR == TypeInterval))
         countR <= initialR;
      // RQ22 decrement per clock
      else if (enableR && !paused && countR != 32'h00000000)
         countR <= countR - 32'h00000001;
   end

   // second-countdown arming and cluster reset pulse
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         armedR <= 1'b0;
         rstCntR <= 3'h0;
      end
      else
      begin
         if (rstCntR != 3'h0)
            rstCntR <= rstCntR - 3'h1;
         // an expiry in the same cycle as a reload still counts
         if (fire && typeR == TypeSecond)
         begin
            // RQ5 RQ15 second expiry resets cluster, unmasked
            if (armedR)
            begin
               rstCntR <= ClusterResetLen;
               armedR <= 1'b0;
            end
            else
               armedR <= 1'b1;
         end
         // software reload forgives the first expiry
         else if (wrEnable)
            armedR <= 1'b0;
      end
   end

   // RQ12 RQ14 pending and mask bits; set wins over clear
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         pendR <= 1'b0;
         maskR <= 1'b0;
      end
      else
      begin
         if (fire)
            pendR <= 1'b1;
         else if (wrEnable)
            pendR <= 1'b0;
         if (wrStb && wb_adr_i == MaskSetOffset && wb_sel_i[0] && wb_dat_i[0])
            maskR <= 1'b1;
         else if (wrStb && wb_adr_i == MaskClearOffset && wb_sel_i[0] && wb_dat_i[0])
            maskR <= 1'b0;
      end
   end

   // routed outputs
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         interruptLines <= 6'h00;
         nmiLine <= 1'b0;
         yieldQualifierLines <= 16'h0000;
         clusterReset <= 1'b0;
      end
      else
      begin
         clusterReset <= rstCntR != 3'h0;
         interruptLines <= 6'h00;
         yieldQualifierLines <= 16'h0000;
         // RQ13 mask gates forwarding
         nmiLine <= pendR && maskR && mapR[MapNmiBit];
         if (pendR && maskR && mapR[MapLineBit])
         begin
            // RQ18 encoded in external mode
            if (eicSyncR[1])
               interruptLines <= mapR[MapFieldHi:0];
            // RQ17 one-hot line select
            else if (mapR[MapFieldHi:0] < 6'h06)
               interruptLines <= 6'h01 << mapR[2:0];
         end
         if (pendR && maskR && mapR[MapYieldBit] && mapR[5:4] == 2'h0)
            yieldQualifierLines <= 16'h0001 << mapR[3:0];
      end
   end

   // RQ10 read mux and ack
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         ackR <= 1'b0;
         datR <= 32'h00000000;
      end
      else
      begin
         ackR <= wb_cyc_i && wb_stb_i && !ackR;
         case (wb_adr_i)
            PendOffset: datR <= {31'h0, pendR};
            MaskStateOffset: datR <= {31'h0, maskR};
            RouteMapOffset: datR <= mapR;
            ConfigOffset: datR <= {25'h0, armedR, waitContR, debugContR, typeR, enableR};
            CountOffset: datR <= countR;
            InitialOffset: datR <= initialR;
            default: datR <= 32'h00000000;
         endcase
      end
   end

   // bus answer straight from its flops
   assign wb_ack_o = ackR;
   assign wb_dat_o = datR;

   // assertions
   property p_oneshot_stop;
      @(posedge ref_clk) disable iff (rst)
      fire && typeR == TypeOneShot && !wrStb |=> !enableR && pendR;
   endproperty
   a_oneshot_stop: assert property (p_oneshot_stop) else $error("one-shot did not stop"); // RQ4
   property p_reload_enable;
      @(posedge ref_clk) disable iff (rst)
      wrEnable |=> countR == $past(initialR);
   endproperty
   a_reload_enable: assert property (p_reload_enable) else $error("no reload on enable"); // RQ8
   property p_pause;
      @(posedge ref_clk) disable iff (rst)
      paused && !wrEnable |=> countR == $past(countR);
   endproperty
   a_pause: assert property (p_pause) else $error("count moved while paused"); // RQ1
   property p_disabled;
      @(posedge ref_clk) disable iff (rst)
      !enableR && !wrEnable |=> $stable(countR);
   endproperty
   a_disabled: assert property (p_disabled) else $error("count moved while disabled"); // RQ7
   property p_decrement;
      @(posedge ref_clk) disable iff (rst)
      enableR && !paused && !wrEnable && countR > 32'h1 |=> countR == $past(countR) - 32'h1;
   endproperty
   a_decrement: assert property (p_decrement) else $error("bad decrement"); // RQ22
   property p_interval;
      @(posedge ref_clk) disable iff (rst)
      expire && typeR == TypeInterval && !wrEnable |=> countR == $past(initialR) && pendR;
   endproperty
   a_interval: assert property (p_interval) else $error("interval reload failed"); // RQ6
   sequence s_second_fire;
      fire && typeR == TypeSecond && armedR && !wrEnable;
   endsequence
   property p_cluster_reset;
      @(posedge ref_clk) disable iff (rst)
      s_second_fire |=> ##1 clusterReset [*4];
   endproperty
   a_cluster_reset: assert property (p_cluster_reset) else $error("no cluster reset"); // RQ15
   property p_mask_gate;
      @(posedge ref_clk) disable iff (rst)
      !maskR |=> interruptLines == 6'h00 && !nmiLine && yieldQualifierLines == 16'h0000;
   endproperty
   a_mask_gate: assert property (p_mask_gate) else $error("masked interrupt forwarded"); // RQ13
   property p_count_ro;
      @(posedge ref_clk) disable iff (rst)
      wrStb && wb_adr_i == CountOffset && !enableR |=> countR == $past(countR);
   endproperty
   a_count_ro: assert property (p_count_ro) else $error("count register was written"); // RQ10
   // expiry, debug pause, routing and register checks
   property p_pend_set;
      @(posedge ref_clk) disable iff (rst)
      fire |=> pendR;
   endproperty
   a_pend_set: assert property (p_pend_set) else $error("pending not set on expiry"); // RQ12
   property p_debug_pause;
      @(posedge ref_clk) disable iff (rst)
      !debugContR && dbgSyncR[1] && !wrEnable |=> $stable(countR);
   endproperty
   a_debug_pause: assert property (p_debug_pause) else $error("count moved in debug"); // RQ2
   sequence s_first_fire;
      fire && typeR == TypeSecond && !armedR;
   endsequence
   property p_second_arm;
      @(posedge ref_clk) disable iff (rst)
      s_first_fire |=> armedR && countR == $past(initialR);
   endproperty
   a_second_arm: assert property (p_second_arm) else $error("first expiry not reloaded"); // RQ5
   property p_line_select;
      @(posedge ref_clk) disable iff (rst)
      pendR && maskR && mapR[MapLineBit] && !eicSyncR[1] && mapField < 6'h06
         |=> interruptLines == 6'h01 << $past(mapField);
   endproperty
   a_line_select: assert property (p_line_select) else $error("wrong interrupt line"); // RQ17
   property p_line_encoded;
      @(posedge ref_clk) disable iff (rst)
      pendR && maskR && mapR[MapLineBit] && eicSyncR[1] |=> interruptLines == $past(mapField);
   endproperty
   a_line_encoded: assert property (p_line_encoded) else $error("wrong encoded line"); // RQ18
   property p_nmi_route;
      @(posedge ref_clk) disable iff (rst)
      pendR && maskR && mapR[MapNmiBit] |=> nmiLine;
   endproperty
   a_nmi_route: assert property (p_nmi_route) else $error("nmi not driven"); // RQ16
   property p_yield_route;
      @(posedge ref_clk) disable iff (rst)
      pendR && maskR && mapR[MapYieldBit] && mapField[5:4] == 2'h0
         |=> $onehot(yieldQualifierLines);
   endproperty
   a_yield_route: assert property (p_yield_route) else $error("yield line not driven"); // RQ16
   property p_count_read;
      @(posedge ref_clk) disable iff (rst)
      wb_cyc_i && wb_stb_i && !ackR && wb_adr_i == CountOffset |=> wb_dat_o == $past(countR);
   endproperty
   a_count_read: assert property (p_count_read) else $error("count read not live"); // RQ10
   property p_initial_write;
      @(posedge ref_clk) disable iff (rst)
      wrStb && wb_adr_i == InitialOffset && wb_sel_i == 4'hf |=> initialR == $past(wb_dat_i);
   endproperty
   a_initial_write: assert property (p_initial_write) else $error("initial write lost"); // RQ11
   property p_mask_set;
      @(posedge ref_clk) disable iff (rst)
      wrStb && wb_adr_i == MaskSetOffset && wb_sel_i[0] && wb_dat_i[0] |=> maskR;
   endproperty
   a_mask_set: assert property (p_mask_set) else $error("mask not set"); // RQ14
   property p_mask_clear;
      @(posedge ref_clk) disable iff (rst)
      wrStb && wb_adr_i == MaskClearOffset && wb_sel_i[0] && wb_dat_i[0] |=> !maskR;
   endproperty
   a_mask_clear: assert property (p_mask_clear) else $error("mask not cleared"); // RQ14
endmodule

/* File: verification/pcwdt_core_model.sv */
`timescale 1ns/1ns
module pcwdt_core_model
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // reset request seen by the processors
   input wire logic clusterReset,
   // length of the last reset pulse in cycles
   output int resetLen
);
   int run;
   // measure each cluster reset pulse as the processors see it
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         run <= 0;
         resetLen <= 0;
      end
      else if (clusterReset)
         run <= run + 1;
      else if (run != 0)
      begin
         resetLen <= run;
         run <= 0;
      end
   end
endmodule

/* File: verification/per_core_watchdog_timer_test.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin failures++; \
   $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
`define WT(c) for (k = 0; k < 80 && !(c); k++) @(posedge ref_clk);
module per_core_watchdog_timer_test;
   import pcwdt_pkg::*;
   logic ref_clk = 0;
   logic rst = 1;
   logic cyc = 0;
   logic stb = 0;
   logic we = 0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'hf;
   logic [31:0] datI = 32'h0;
   logic [31:0] datO, rd, rd2;
   logic ack, nmi, cRst;
   logic waitSt = 0;
   logic dbg = 0;
   logic ext = 0;
   logic [5:0] lines;
   logic [15:0] yq;
   int failures = 0;
   int nChecks = 0;
   int k, resetLen;
   // block under test and the processor side
   pcwdt_top uut (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO),
      .wb_ack_o(ack), .waitState(waitSt), .debugModeFlag(dbg),
      .externalControllerMode(ext), .interruptLines(lines), .nmiLine(nmi),
      .yieldQualifierLines(yq), .clusterReset(cRst));
   pcwdt_core_model partner (.ref_clk(ref_clk), .rst(rst), .clusterReset(cRst),
      .resetLen(resetLen));
   // 100 ns clock
   initial
   begin
      forever #50 ref_clk = ~ref_clk;
   end
   // one classic wishbone cycle, held until ack is sampled
   task wbAcc(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      datI <= d;
      sel <= 4'hf;
      do
         @(posedge ref_clk);
      while (ack !== 1'b1);
      rd = datO;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task arm(input logic [2:0] ty, input logic [31:0] init);
      wbAcc(1'b1, ConfigOffset, 32'h0);
      wbAcc(1'b1, InitialOffset, init);
      wbAcc(1'b1, ConfigOffset, {28'h0, ty, 1'b1});
   endtask
   // final verdict
   task giveVerdict;
      if (failures == 0 && nChecks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // cut a hang short
   initial
   begin
      repeat (5000) @(posedge ref_clk);
      failures++;
      giveVerdict();
   end
   // test sequence
   initial
   begin
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      wbAcc(1'b0, RouteMapOffset, 32'h0);
      `CHK(rd, 32'h80000000)
      wbAcc(1'b0, MaskStateOffset, 32'h0);
      `CHK(rd[0], 1'b0)
      wbAcc(1'b1, CountOffset, 32'h55);
      wbAcc(1'b0, CountOffset, 32'h0);
      `CHK(rd, 32'h0)
      wbAcc(1'b0, 8'h20, 32'h0);
      `CHK(rd, 32'h0)
      wbAcc(1'b1, InitialOffset, 32'ha5c30f01);
      wbAcc(1'b0, InitialOffset, 32'h0);
      `CHK(rd, 32'ha5c30f01)
      wbAcc(1'b1, MaskSetOffset, 32'h1);
      wbAcc(1'b0, MaskStateOffset, 32'h0);
      `CHK(rd[0], 1'b1)
      wbAcc(1'b1, RouteMapOffset, 32'h80000002);
      arm(TypeOneShot, 32'h8);
      `WT(lines === 6'h04)
      `CHK(lines, 6'h04)
      wbAcc(1'b0, PendOffset, 32'h0);
      `CHK(rd[0], 1'b1)
      wbAcc(1'b0, CountOffset, 32'h0);
      `CHK(rd, 32'h0)
      wbAcc(1'b0, ConfigOffset, 32'h0);
      `CHK(rd[0], 1'b0)
      arm(TypeInterval, 32'h8);
      // let the cleared pending bit reach the lines before waiting
      @(posedge ref_clk);
      `WT(lines === 6'h04)
      `CHK(lines, 6'h04)
      wbAcc(1'b0, CountOffset, 32'h0);
      rd2 = rd;
      wbAcc(1'b0, CountOffset, 32'h0);
      `CHK(rd !== rd2 && rd <= 32'h8, 1'b1)
      ext <= 1'b1;
      wbAcc(1'b1, RouteMapOffset, 32'h8000002a);
      `WT(lines === 6'h2a)
      `CHK(lines, 6'h2a)
      ext <= 1'b0;
      wbAcc(1'b1, RouteMapOffset, 32'h40000000);
      `WT(nmi === 1'b1)
      `CHK({nmi, lines}, 7'h40)
      wbAcc(1'b1, RouteMapOffset, 32'h20000003);
      `WT(yq === 16'h0008)
      `CHK({nmi, yq}, 17'h00008)
      for (int n = 0; n < 6; n++)
      begin
         wbAcc(1'b1, RouteMapOffset, 32'h80000000 | n);
         `WT(lines === 6'(1 << n))
         `CHK(lines, 6'(1 << n))
      end
      wbAcc(1'b1, ConfigOffset, 32'h6);
      wbAcc(1'b0, CountOffset, 32'h0);
      rd2 = rd;
      wbAcc(1'b0, CountOffset, 32'h0);
      `CHK(rd, rd2)
      wbAcc(1'b1, MaskClearOffset, 32'h1);
      `WT(lines === 6'h0)
      `CHK(lines, 6'h0)
      // pause on wait state, then on debug mode
      for (int i = 0; i < 2; i++)
      begin
         waitSt <= (i == 0);
         dbg <= (i == 1);
         arm(3'h0, 32'h40);
         wbAcc(1'b0, CountOffset, 32'h0);
         `CHK(rd, 32'h40)
         wbAcc(1'b1, ConfigOffset, 32'h1 | (32'h20 >> i));
         wbAcc(1'b0, CountOffset, 32'h0);
         `CHK(rd < 32'h40, 1'b1)
         wbAcc(1'b0, ConfigOffset, 32'h0);
         `CHK(rd[5:4], 2'(2 >> i))
      end
      waitSt <= 1'b0;
      dbg <= 1'b0;
      wbAcc(1'b1, RouteMapOffset, 32'h40000000);
      arm(TypeSecond, 32'h8);
      `WT(cRst === 1'b1)
      `CHK(cRst === 1'b1 && k > 10, 1'b1)
      `CHK(nmi, 1'b0)
      repeat (10) @(posedge ref_clk);
      `CHK(resetLen, ClusterResetCycles)
      giveVerdict();
   end
endmodule
